// *** shared/tmc_pkg.sv ***
`default_nettype none
package tmc_pkg;
   // ***********************************************************
   // Bus geometry
   // ***********************************************************
   localparam int          ADR_W        = 18;
   localparam int          DAT_W        = 32;

   // ***********************************************************
   // Register indices (byte address is four times the index)
   // ***********************************************************
   localparam logic [15:0] IDX_CTRL     = 16'hA003;
   localparam logic [15:0] IDX_CNT_LO   = 16'hA004;
   localparam logic [15:0] IDX_CNT_MID  = 16'hA005;
   localparam logic [15:0] IDX_CNT_HI   = 16'hA006;
   localparam logic [15:0] IDX_STATUS   = 16'hA008;
   localparam logic [15:0] IDX_CLEAR    = 16'hA009;
   localparam logic [15:0] IDX_IRQ_EN   = 16'hA00A;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int          CTRL_SEL_LSB = 0;
   localparam int          CTRL_MODE    = 2;
   localparam int          CTRL_RUN     = 3;
   localparam int          STAT_OVF     = 0;

   // ***********************************************************
   // Reset values and counts
   // ***********************************************************
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [23:0] CNT_RST      = 24'h000000;
   localparam logic [23:0] RELOAD_RST   = 24'h000000;
   localparam logic [23:0] CNT_MAX      = 24'hFFFFFF;
   localparam logic [0:0]  STAT_RST     = 1'h0;
   localparam logic [0:0]  IRQ_EN_RST   = 1'h0;
   localparam logic [7:0]  DIV_RST      = 8'h00;
   localparam logic [7:0]  INT_DIV      = 8'h01;
   localparam logic [7:0]  SLOW_DIV     = 8'h10;

   typedef enum logic [1:0] {
      TMC_SEL_INT_A  = 2'h0,
      TMC_SEL_INT_B  = 2'h1,
      TMC_SEL_SLOW_A = 2'h2,
      TMC_SEL_SLOW_B = 2'h3
   } tmc_clk_sel_t;
endpackage
`default_nettype wire

// *** core/tmc_tick_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module tmc_tick_gen (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] count_clock_select,
   output var  logic       tick_o
);
   import tmc_pkg::*;

   logic [7:0] int_cnt_q;
   logic [7:0] slow_cnt_q;
   logic       int_pulse;
   logic       slow_pulse;

   assign int_pulse  = (int_cnt_q == INT_DIV - 8'h01);
   assign slow_pulse = (slow_cnt_q == SLOW_DIV - 8'h01);

   // Both dividers run always so a select change never waits a full period
   always_ff @(posedge clk) begin
      if (sys_rst || int_pulse) begin
         int_cnt_q <= DIV_RST;
      end else begin
         int_cnt_q <= int_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || slow_pulse) begin
         slow_cnt_q <= DIV_RST;
      end else begin
         slow_cnt_q <= slow_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= count_clock_select[1] ? slow_pulse : int_pulse; // see RULE8
      end
   end

   slow_gap_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE8
      (count_clock_select[1] && slow_cnt_q != SLOW_DIV - 8'h01) |=> !tick_o)
      else $error("Tick from slow source off its period");
   int_gap_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE8
      !count_clock_select[1] |=> (tick_o == $past(int_pulse)))
      else $error("Tick from internal source off its period");
endmodule // tmc_tick_gen
`default_nettype wire

// *** core/tmc_timer.sv ***
// Behaviour
// RULE1 - Count is one 24-bit value, three bytes
// RULE2 - Reload mode: byte writes go to reload
// RULE3 - Free-run mode: byte writes load count now
// RULE4 - Byte reads always return live count
// RULE5 - Software reads high byte first, low last
// RULE6 - Mode bit: 1 reload, 0 free-run
// RULE7 - Overflow sets sticky flag until software clears
// RULE8 - Select 00/01 internal, 10/11 slow oscillator
// RULE9 - Run bit set counts, clear holds
// RULE10 - Reload mode overflow loads reload value
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module tmc_timer (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [tmc_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [tmc_pkg::DAT_W-1:0] wb_dat_i,
   output var  logic [tmc_pkg::DAT_W-1:0] wb_dat_o,
   output var  logic                      wb_ack_o,
   output var  logic                      irq_o
);
   import tmc_pkg::*;

   // ***********************************************************
   // Decode helpers
   // ***********************************************************
   function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
      hit = (adr[ADR_W-1:2] == idx);
   endfunction

   function automatic logic [2:0] cnt_lane(input logic [ADR_W-1:0] adr);
      cnt_lane = {hit(adr, IDX_CNT_HI), hit(adr, IDX_CNT_MID), hit(adr, IDX_CNT_LO)};
   endfunction

   logic [23:0] aux_timer_count_q;
   logic [23:0] reload_q;
   logic [1:0]  count_clock_select_q;
   logic        reload_mode_select_q;
   logic        run_control_q;
   logic        overflow_flag_q;
   logic        overflow_irq_enable_q;
   logic        access;
   logic        wr_acc;
   logic [2:0]  lane;
   logic        cnt_wr;
   logic        tick;
   logic        ovf_evt;
   logic        ovf_clr;
   logic [31:0] rd_d;

   assign access  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_acc  = access && wb_we_i && wb_sel_i[0];
   assign lane    = cnt_lane(wb_adr_i);
   assign cnt_wr  = wr_acc && !reload_mode_select_q && (lane != 3'h0);
   assign ovf_evt = run_control_q && tick && (aux_timer_count_q == CNT_MAX) && !cnt_wr;
   assign ovf_clr = wr_acc && hit(wb_adr_i, IDX_CLEAR) && wb_dat_i[STAT_OVF];

   // ***********************************************************
   // Count clock source
   // ***********************************************************
   tmc_tick_gen u_tick (
      .clk                (clk),
      .sys_rst            (sys_rst),
      .count_clock_select (count_clock_select_q),
      .tick_o             (tick)
   );

   // ***********************************************************
   // Control and interrupt enable
   // ***********************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_clock_select_q <= CTRL_RST[CTRL_SEL_LSB+:2];
         reload_mode_select_q <= CTRL_RST[CTRL_MODE];
         run_control_q        <= CTRL_RST[CTRL_RUN];
      end else if (wr_acc && hit(wb_adr_i, IDX_CTRL)) begin
         count_clock_select_q <= wb_dat_i[CTRL_SEL_LSB+:2];
         reload_mode_select_q <= wb_dat_i[CTRL_MODE]; // see RULE6
         run_control_q        <= wb_dat_i[CTRL_RUN];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overflow_irq_enable_q <= IRQ_EN_RST;
      end else if (wr_acc && hit(wb_adr_i, IDX_IRQ_EN)) begin
         overflow_irq_enable_q <= wb_dat_i[STAT_OVF];
      end
   end

   // ***********************************************************
   // Reload value and live count
   // ***********************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reload_q <= RELOAD_RST;
      end else if (wr_acc && reload_mode_select_q) begin
         for (int i = 0; i < 3; i++) begin
            if (lane[i]) begin
               reload_q[i*8+:8] <= wb_dat_i[7:0]; // see RULE2
            end
         end
      end
   end

   // A software load wins over a tick in the same cycle; that tick is dropped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_timer_count_q <= CNT_RST; // see RULE1
      end else if (cnt_wr) begin
         for (int i = 0; i < 3; i++) begin
            if (lane[i]) begin
               aux_timer_count_q[i*8+:8] <= wb_dat_i[7:0]; // see RULE3
            end
         end
      end else if (run_control_q && tick) begin // see RULE9
         if (aux_timer_count_q == CNT_MAX) begin
            aux_timer_count_q <= reload_mode_select_q ? reload_q : CNT_RST; // see RULE10
         end else begin
            aux_timer_count_q <= aux_timer_count_q + 24'h000001;
         end
      end
   end

   // ***********************************************************
   // Status and interrupt
   // ***********************************************************
   // Set wins over clear so an overflow in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overflow_flag_q <= STAT_RST;
      end else if (ovf_evt) begin
         overflow_flag_q <= 1'b1; // see RULE7
      end else if (ovf_clr) begin
         overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (overflow_flag_q || ovf_evt) && overflow_irq_enable_q;
      end
   end

   // ***********************************************************
   // Wishbone read mux and acknowledge
   // ***********************************************************
   // No snapshot: a multi-byte read can tear, software orders the bytes
   always_comb begin
      rd_d = 32'h00000000;
      if (hit(wb_adr_i, IDX_CNT_LO)) begin
         rd_d[7:0] = aux_timer_count_q[7:0]; // see RULE4
      end else if (hit(wb_adr_i, IDX_CNT_MID)) begin
         rd_d[7:0] = aux_timer_count_q[15:8]; // see RULE4
      end else if (hit(wb_adr_i, IDX_CNT_HI)) begin
         rd_d[7:0] = aux_timer_count_q[23:16]; // see RULE4
      end else if (hit(wb_adr_i, IDX_CTRL)) begin
         rd_d[CTRL_SEL_LSB+:2] = count_clock_select_q;
         rd_d[CTRL_MODE]       = reload_mode_select_q;
         rd_d[CTRL_RUN]        = run_control_q;
      end else if (hit(wb_adr_i, IDX_STATUS)) begin
         rd_d[STAT_OVF] = overflow_flag_q;
      end else if (hit(wb_adr_i, IDX_IRQ_EN)) begin
         rd_d[STAT_OVF] = overflow_irq_enable_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= (access && !wb_we_i) ? rd_d : 32'h00000000;
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   ack_single_a: assert property (@(posedge clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge held longer than one cycle");
   read_live_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
      (access && !wb_we_i && hit(wb_adr_i, IDX_CNT_HI)) |=> wb_dat_o[7:0] == $past(aux_timer_count_q[23:16]))
      else $error("High byte read did not return live count");
   reload_write_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
      (wr_acc && reload_mode_select_q && lane[0]) |=> reload_q[7:0] == $past(wb_dat_i[7:0]))
      else $error("Reload byte not written in reload mode");
   reload_keeps_cnt_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
      (wr_acc && reload_mode_select_q && lane[1] && !run_control_q) |=> $stable(aux_timer_count_q))
      else $error("Reload mode write disturbed the count");
   free_write_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
      (wr_acc && !reload_mode_select_q && lane[1]) |=> aux_timer_count_q[15:8] == $past(wb_dat_i[7:0]))
      else $error("Free-run write did not load the count");
   ovf_sticky_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE7
      (overflow_flag_q && !ovf_clr) |=> overflow_flag_q)
      else $error("Overflow flag dropped without a clear");
   ovf_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE7
      ovf_evt |=> overflow_flag_q ##1 (overflow_flag_q || $past(ovf_clr)))
      else $error("Overflow did not set the flag");
   reload_load_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE10
      (ovf_evt && reload_mode_select_q) |=> aux_timer_count_q == $past(reload_q))
      else $error("Reload value not loaded on overflow");
   free_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE6
      (ovf_evt && !reload_mode_select_q) |=> aux_timer_count_q == CNT_RST)
      else $error("Free-run count did not wrap to zero");
   stop_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
      (!run_control_q && !cnt_wr) |=> $stable(aux_timer_count_q))
      else $error("Stopped counter moved");
   irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
      (overflow_flag_q && overflow_irq_enable_q) |=> irq_o)
      else $error("Enabled flag did not raise interrupt");

   ovf_reload_c: cover property (@(posedge clk) disable iff (sys_rst) ovf_evt && reload_mode_select_q);
   ovf_free_c:   cover property (@(posedge clk) disable iff (sys_rst) ovf_evt && !reload_mode_select_q);
   set_clear_c:  cover property (@(posedge clk) disable iff (sys_rst) ovf_evt && ovf_clr);
   irq_c:        cover property (@(posedge clk) disable iff (sys_rst) irq_o);
endmodule // tmc_timer
`default_nettype wire

// *** verification/test_timer_counter_24bit_access.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_timer_counter_24bit_access;
   import tmc_pkg::*;
   logic             clk;
   logic             sys_rst;
   logic             cyc;
   logic             stb;
   logic             we;
   logic [ADR_W-1:0] adr;
   logic [3:0]       sel;
   logic [DAT_W-1:0] wdat;
   logic [DAT_W-1:0] rdat;
   logic             ack;
   logic             irq;
   int               n_errors = 0;
   int               cmp_count = 0;
   int               cycles = 0;
   logic [31:0]      seed = 32'h2049;
   logic [23:0]      m_cnt;
   logic [23:0]      m_rel;
   logic             m_mode;
   logic [31:0]      q;
   logic [15:0]      got;
   logic [3:0]       sel_v = 4'h1;
   logic [15:0]      idx_tbl [7] = '{IDX_CTRL, IDX_CNT_LO, IDX_CNT_MID, IDX_CNT_HI, IDX_STATUS, IDX_IRQ_EN, 16'hA00F};

   tmc_timer u_tmc_timer (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .wb_cyc_i (cyc),
      .wb_stb_i (stb),
      .wb_we_i  (we),
      .wb_adr_i (adr),
      .wb_sel_i (sel),
      .wb_dat_i (wdat),
      .wb_dat_o (rdat),
      .wb_ack_o (ack),
      .irq_o    (irq)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Ack is sampled at the edge itself, so read data is the value of the ack cycle
   task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      sel  <= sel_v;
      wdat <= {24'h0, d};
      @(posedge clk iff ack === 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic ctrl(input logic [7:0] v);
      bus(IDX_CTRL, 1'b1, v);
      m_mode = v[CTRL_MODE];
   endtask

   task automatic wr_cnt(input logic [23:0] v);
      bus(IDX_CNT_HI, 1'b1, v[23:16]);
      bus(IDX_CNT_MID, 1'b1, v[15:8]);
      bus(IDX_CNT_LO, 1'b1, v[7:0]);
      if (m_mode) m_rel = v;
      else m_cnt = v;
   endtask

   // High byte first: no snapshot, so a moving count would tear otherwise
   task automatic chk_cnt(input int nbytes);
      bus(IDX_CNT_HI, 1'b0, 8'h00);
      check("count_hi", q, {24'h0, m_cnt[23:16]});
      bus(IDX_CNT_MID, 1'b0, 8'h00);
      check("count_mid", q, {24'h0, m_cnt[15:8]});
      if (nbytes == 3) begin
         bus(IDX_CNT_LO, 1'b0, 8'h00);
         check("count_lo", q, {24'h0, m_cnt[7:0]});
      end
   endtask

   task automatic wait_ovf;
      for (int k = 0; k < 300; k++) begin
         bus(IDX_STATUS, 1'b0, 8'h00);
         if (q[STAT_OVF] === 1'b1) break;
      end
      check("status_set", q, 32'h1);
   endtask

   task automatic chk_irq(input logic exp);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         final_report();
      end
   end

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      sys_rst = 1'b1;
      {cyc, stb, we, sel, adr, wdat} = '0;
      m_mode = 1'b0;
      m_cnt = CNT_RST;
      m_rel = RELOAD_RST;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (idx_tbl[i]) begin
         bus(idx_tbl[i], 1'b0, 8'h00);
         check("reset_value", q, 32'h0);
      end
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         wr_cnt(seed[23:0]);
         chk_cnt(3);
      end
      // A write without lane 0 enabled is acked but must leave the count alone
      sel_v = 4'h0;
      bus(IDX_CNT_LO, 1'b1, ~m_cnt[7:0]);
      sel_v = 4'h1;
      chk_cnt(3);
      ctrl(8'h00);
      wr_cnt(24'hFFFFF8);
      ctrl(8'h04);
      wr_cnt(24'h5A3C00);
      chk_cnt(3);
      bus(IDX_IRQ_EN, 1'b1, 8'h01);
      chk_irq(1'b0);
      ctrl(8'h0C);
      wait_ovf();
      ctrl(8'h04);
      m_cnt = m_rel;
      chk_cnt(2);
      chk_irq(1'b1);
      bus(IDX_IRQ_EN, 1'b1, 8'h00);
      chk_irq(1'b0);
      bus(IDX_STATUS, 1'b0, 8'h00);
      check("status_sticky", q, 32'h1);
      bus(IDX_IRQ_EN, 1'b1, 8'h01);
      chk_irq(1'b1);
      bus(IDX_CLEAR, 1'b1, 8'h01);
      chk_irq(1'b0);
      bus(IDX_STATUS, 1'b0, 8'h00);
      check("status_clear", q, 32'h0);
      ctrl(8'h00);
      wr_cnt(24'hFFFFF0);
      ctrl(8'h08);
      wait_ovf();
      ctrl(8'h00);
      m_cnt = 24'h000000;
      chk_cnt(2);
      chk_irq(1'b1);
      bus(IDX_CLEAR, 1'b1, 8'h01);
      for (int i = 0; i < 4; i++) begin
         ctrl(8'h00);
         wr_cnt(24'h000000);
         ctrl({4'h0, 1'b1, 1'b0, i[1:0]});
         repeat (160) @(posedge clk);
         ctrl(8'h00);
         bus(IDX_CNT_MID, 1'b0, 8'h00);
         got[15:8] = q[7:0];
         bus(IDX_CNT_LO, 1'b0, 8'h00);
         got[7:0] = q[7:0];
         // Slow source ticks once per SLOW_DIV cycles; allow a few cycles of bus latency
         check("rate", {31'h0, ((int'(got) - (i[1] ? 163 / int'(SLOW_DIV) : 163 / int'(INT_DIV))) inside {[-4:4]})}, 32'h1);
         repeat (20) @(posedge clk);
         bus(IDX_CNT_LO, 1'b0, 8'h00);
         check("held", q, {24'h0, got[7:0]});
      end
      final_report();
   end
endmodule // test_timer_counter_24bit_access
`default_nettype wire
